// ### verif/lcd_display_setup_commands_tb.sv
// Self-checking bench for the setup command decoder
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module lcd_display_setup_commands_tb;
  logic sys_clk = 0, rst_n = 0, go = 0, mem_access = 0, mem_write = 0, osc = 1;
  logic row_strobe = 0, frame_strobe = 0, cmd_valid, pol, hd;
  logic [7:0] hb = 8'h00, lf = 8'h4A;
  ldsc_pkg::ldsc_bank_t mem_bank = ldsc_pkg::LDSC_BANK_DISPLAY;
  ldsc_pkg::ldsc_cmd_t cmd;
  ldsc_pkg::ldsc_cfg_t cfg;
  logic [6:0] ac, duty;
  logic [5:0] sh;
  logic [4:0] rc [3] = '{5'h00, 5'h10, 5'h14};
  logic [6:0] rd [3] = '{7'h32, 7'h0B, 7'h14};
  int n_fail = 0, checks = 0, step = 1, shen = 0, eac = 0, esh = 0, epol = 0;
  int e2 = 0, em = 0, einv = 0, erate = 7;
  always #25 sys_clk = ~sys_clk;
  ldsc_host host (.sys_clk(sys_clk), .go(go), .cmd_byte(hb), .cmd_valid(cmd_valid), .cmd(cmd));
  ldsc_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .mem_access(mem_access), .mem_write(mem_write), .mem_bank(mem_bank),
    .row_strobe(row_strobe), .frame_strobe(frame_strobe), .osc_internal_pin(osc),
    .cfg(cfg), .address_counter(ac), .shift_offset(sh), .drive_polarity(pol),
    .duty_on_pct(duty), .home_done(hd));
  // Shift register source of random values
  function automatic logic [7:0] rnd(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : rnd
  // Compare configuration, address, shift and polarity outputs against the model
  task automatic chk_all();
    `CHK("cfg", {step[0], shen[0], e2[0], em[0], einv[2:0], erate[4:0]}, cfg)
    `CHK("addr", eac[6:0], ac)
    `CHK("shift", esh[5:0], sh)
    `CHK("pol", epol[0], pol)
  endtask : chk_all
  // One control write through the host, then model update
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk) begin go <= 1; hb <= b; end
    @(posedge sys_clk) go <= 0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (b == 8'h01) begin eac = 0; esh = 0; end
    if (b[7:2] == 6'h0A) begin step = b[1]; shen = b[0]; end
    if (b[7:2] == 6'h0C) begin e2 = b[1]; em = b[0]; end
    if (b[7:3] == 5'h08) einv = b[2:0];
    if (b[7:5] == 3'h4 && osc) erate = b[4:0];
    `CHK("home", b == 8'h01, hd)
    chk_all();
  endtask : send
  // One memory access
  task automatic mem(input logic w, input logic [1:0] bk);
    @(posedge sys_clk) begin mem_access <= 1; mem_write <= w;
      mem_bank <= ldsc_pkg::ldsc_bank_t'(bk); end
    @(posedge sys_clk) mem_access <= 0;
    @(negedge sys_clk);
    if (bk != 2'h3) eac = (eac + (step ? 1 : 127)) % 128;
    if (w && bk == 2'h0 && shen) esh = (esh + (step ? 1 : 39)) % 40;
    chk_all();
  endtask : mem
  // One row or frame pulse
  task automatic strb(input logic r, input logic f);
    @(posedge sys_clk) begin row_strobe <= r; frame_strobe <= f; end
    @(posedge sys_clk) begin row_strobe <= 0; frame_strobe <= 0; end
  endtask : strb
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    @(negedge sys_clk);
    chk_all();
    `CHK("duty", 7'h0B, duty)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      send(8'h28 | i[7:0]);
      repeat (6) begin
        lf = rnd(lf);
        mem(lf[0], lf[2:1]);
      end
    end
    send(8'h01);
    send(8'h30);
    for (int i = 1; i < 4; i++) send(8'h30 | i[7:0]);
    $display("test entry home function done");
    for (int i = 0; i < 3; i++) begin
      send(8'h80 | {3'h0, rc[i]});
      `CHK("duty", rd[i], duty)
    end
    @(posedge sys_clk) osc <= 0;
    repeat (4) @(posedge sys_clk);
    send(8'h85);
    `CHK("duty", rd[2], duty)
    @(posedge sys_clk) osc <= 1;
    repeat (2) @(posedge sys_clk);
    $display("test rate done");
    for (int n = 0; n < 8; n++) begin
      send(8'h40 | n[7:0]);
      for (int k = 0; k < (n == 0 ? 1 : n); k++) strb(n != 0, n == 0);
      epol = 1 - epol;
      @(negedge sys_clk) chk_all();
    end
    $display("test inversion done");
    stop_test();
  end
endmodule : lcd_display_setup_commands_tb

// ### verif/ldsc_host.sv
// Host model issuing control writes
`timescale 1ns/10ps
module ldsc_host (
  input  wire logic          sys_clk,
  input  wire logic          go,
  input  wire logic [7:0]    cmd_byte,
  output logic               cmd_valid,
  output ldsc_pkg::ldsc_cmd_t cmd
);
  initial cmd_valid = 1'h0;
  initial cmd = '0;
  // One write per request; idle bus inverts its last value every cycle
  always @(posedge sys_clk) begin
    cmd_valid <= go;
    cmd <= go ? {2'h2, 1'h0, cmd_byte} : ~cmd;
  end
endmodule : ldsc_host

// ### verif/ldsc_monitor.sv
// Port property checker for the setup command decoder
`timescale 1ns/10ps
module ldsc_monitor (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 cmd_valid,
  input wire ldsc_pkg::ldsc_cmd_t  cmd,
  input wire logic                 mem_access,
  input wire logic                 mem_write,
  input wire ldsc_pkg::ldsc_bank_t mem_bank,
  input wire logic                 row_strobe,
  input wire logic                 frame_strobe,
  input wire logic                 osc_internal_pin,
  input wire ldsc_pkg::ldsc_cfg_t  cfg,
  input wire logic [6:0]           address_counter,
  input wire logic [5:0]           shift_offset,
  input wire logic                 drive_polarity,
  input wire logic [6:0]           duty_on_pct,
  input wire logic                 home_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Decoded control writes and display memory writes
  wire ctl = cmd_valid && cmd.register_select == ldsc_pkg::RS_CTRL && !cmd.read_not_write;
  wire home = ctl && cmd.data == ldsc_pkg::OP_HOME;
  wire inv = ctl && cmd.data[7:3] == ldsc_pkg::OP_INV_HI;
  wire shw = mem_access && mem_write && mem_bank == ldsc_pkg::LDSC_BANK_DISPLAY;
  home_clear_a:
    assert property (home |=> address_counter == 7'h00 && shift_offset == 6'h00 && home_done)
    else $error("home left position set");
  home_pulse_a:
    assert property (home_done |-> $past(home)) else $error("stray home done");
  home_keep_a:
    assert property (home |=> cfg == $past(cfg)) else $error("home changed settings");
  entry_set_a:
    assert property (ctl && cmd.data[7:2] == ldsc_pkg::OP_ENTRY_HI |=>
      {cfg.step_dir, cfg.shift_en} == $past(cmd.data[1:0])) else $error("entry mode wrong");
  func_set_a:
    assert property (ctl && cmd.data[7:2] == ldsc_pkg::OP_FUNC_HI |=>
      {cfg.two_line, cfg.mux_ratio_select} == $past(cmd.data[1:0])) else $error("func wrong");
  inv_set_a:
    assert property (inv |=> cfg.polarity_scheme_code == $past(cmd.data[2:0]))
    else $error("inversion code wrong");
  rate_set_a:
    assert property (ctl && cmd.data[7:5] == ldsc_pkg::OP_RATE_HI &&
      $past(osc_internal_pin, 2) |=> cfg.refresh_rate_code == $past(cmd.data[4:0]))
    else $error("rate code not stored");
  addr_step_a:
    assert property (mem_access && mem_bank != ldsc_pkg::LDSC_BANK_ROM && !home |=>
      address_counter == $past(address_counter) + ($past(cfg.step_dir) ? 7'h01 : 7'h7F))
    else $error("address step wrong");
  no_shift_a:
    assert property (mem_access && !shw && !home |=> $stable(shift_offset))
    else $error("display shifted");
  frame_flip_a:
    assert property (cfg.polarity_scheme_code == 3'h0 && frame_strobe && !inv |=>
      drive_polarity != $past(drive_polarity)) else $error("no frame toggle");
  line_flip_a:
    assert property (cfg.polarity_scheme_code == 3'h1 && row_strobe && !frame_strobe && !inv
      |=> drive_polarity != $past(drive_polarity)) else $error("no row toggle");
  // Main scenarios reached
  cover property (home);
  cover property (shw && cfg.shift_en);
  cover property (inv ##[1:40] frame_strobe);
endmodule : ldsc_monitor
bind ldsc_core ldsc_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd(cmd), .mem_access(mem_access), .mem_write(mem_write), .mem_bank(mem_bank),
  .row_strobe(row_strobe), .frame_strobe(frame_strobe), .osc_internal_pin(osc_internal_pin),
  .cfg(cfg), .address_counter(address_counter), .shift_offset(shift_offset),
  .drive_polarity(drive_polarity), .duty_on_pct(duty_on_pct), .home_done(home_done));

// ### verilog/ldsc_core.sv
// Decoder for return home, entry mode, function set, inversion and refresh rate commands
//
// Summary of operation
// - Control write 00000001 zeroes the address counter and unshifts the display.
// - Return home cancels all accumulated display shift.
// - Return home puts cursor at line one left; keeps step and shift flags.
// - Entry mode: control write 001010xx; bit1 step direction (reset 1), bit0 shift (reset 0).
// - Every memory data access except to the ROM bank steps the address counter by one per direction.
// - Display memory write with shift enabled shifts display; left if step is up.
// - No shift on reads or on pattern or icon memory accesses.
// - Function set 001100xx; bit1 picks 1x40 (reset) or 2x20 layout.
// - Function set bit0 picks mux 1:18 (reset) or 1:9.
// - Inversion 01000xxx; code 0 frame inversion, codes 1..7 n-line inversion.
// - n-line mode toggles drive polarity after every n rows; a frame pulse restarts the row count.
// - Frame mode toggles drive polarity once per frame.
// - Refresh rate 100xxxxx; code applies only with internal oscillator as source.
// - Refresh rate after reset is the 80 Hz default code.
// - Duty cycle output follows the selected refresh rate code.
`timescale 1ns/10ps

module ldsc_core #(
  parameter int LINE_CHARS = ldsc_pkg::LINE_LEN
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic                            cmd_valid,
  input  wire ldsc_pkg::ldsc_cmd_t             cmd,
  input  wire logic                            mem_access,
  input  wire logic                            mem_write,
  input  wire ldsc_pkg::ldsc_bank_t            mem_bank,
  input  wire logic                            row_strobe,
  input  wire logic                            frame_strobe,
  input  wire logic                            osc_internal_pin,
  output ldsc_pkg::ldsc_cfg_t                  cfg,
  output logic [ldsc_pkg::ADDR_W-1:0]          address_counter,
  output logic [ldsc_pkg::SHIFT_W-1:0]         shift_offset,
  output logic                                 drive_polarity,
  output logic [6:0]                           duty_on_pct,
  output logic                                 home_done
);

  // Oscillator source pin synchroniser
  logic osc_meta;
  logic osc_sync;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= osc_internal_pin;
      osc_sync <= osc_meta;
    end
  end

  // Instruction decode
  wire is_ctrl_wr = cmd_valid && !cmd.read_not_write
                    && (cmd.register_select == ldsc_pkg::RS_CTRL);
  wire dec_home   = is_ctrl_wr && (cmd.data == ldsc_pkg::OP_HOME);
  wire dec_entry  = is_ctrl_wr && (cmd.data[7:2] == ldsc_pkg::OP_ENTRY_HI);
  wire dec_func   = is_ctrl_wr && (cmd.data[7:2] == ldsc_pkg::OP_FUNC_HI);
  wire dec_inv    = is_ctrl_wr && (cmd.data[7:3] == ldsc_pkg::OP_INV_HI);
  wire dec_rate   = is_ctrl_wr && (cmd.data[7:5] == ldsc_pkg::OP_RATE_HI);
  wire rate_ok    = dec_rate && osc_sync;

  // Next configuration: each command touches only its own fields
  ldsc_pkg::ldsc_cfg_t next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (dec_entry) begin
      next_cfg.step_dir = cmd.data[1];
      next_cfg.shift_en = cmd.data[0];
    end
    if (dec_func) begin
      next_cfg.two_line         = cmd.data[1];
      next_cfg.mux_ratio_select = cmd.data[0];
    end
    if (dec_inv) begin
      next_cfg.polarity_scheme_code = cmd.data[2:0];
    end
    if (rate_ok) begin
      next_cfg.refresh_rate_code = cmd.data[4:0];
    end
  end

  // Configuration store; return home leaves step and shift flags alone
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= ldsc_pkg::RST_CFG;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Duty cycle tracks the selected rate code
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_on_pct <= ldsc_pkg::RST_DUTY;
    end else begin
      duty_on_pct <= ldsc_pkg::ldsc_duty(next_cfg.refresh_rate_code);
    end
  end

  // Address stepping and display shift on data accesses
  wire step_evt   = mem_access && (mem_bank != ldsc_pkg::LDSC_BANK_ROM);
  wire shift_evt  = mem_access && mem_write && cfg.shift_en
                    && (mem_bank == ldsc_pkg::LDSC_BANK_DISPLAY);

  localparam logic [ldsc_pkg::SHIFT_W-1:0] SHIFT_MAX =
    ldsc_pkg::SHIFT_W'(LINE_CHARS - 1);

  logic [ldsc_pkg::ADDR_W-1:0]  next_addr;
  logic [ldsc_pkg::SHIFT_W-1:0] next_shift;

  always_comb begin
    next_addr  = address_counter;
    next_shift = shift_offset;
    if (step_evt) begin
      if (cfg.step_dir) begin
        next_addr = address_counter + 7'h01;
      end else begin
        next_addr = address_counter - 7'h01;
      end
    end
    if (shift_evt) begin
      if (cfg.step_dir) begin
        // Shift left: window origin moves forward
        next_shift = (shift_offset == SHIFT_MAX) ? 6'h00 : shift_offset + 6'h01;
      end else begin
        // Shift right: window origin moves back
        next_shift = (shift_offset == 6'h00) ? SHIFT_MAX : shift_offset - 6'h01;
      end
    end
    if (dec_home) begin
      next_addr  = '0;
      next_shift = '0;
    end
  end

  // Address counter, shift offset and home pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_counter <= '0;
      shift_offset    <= '0;
      home_done       <= 1'b0;
    end else begin
      address_counter <= next_addr;
      shift_offset    <= next_shift;
      home_done       <= dec_home;
    end
  end

  // Inversion scheme: frame mode or n-line mode
  logic [2:0] row_count;
  wire        frame_mode = (cfg.polarity_scheme_code == 3'h0);
  wire        row_wrap   = row_strobe && !frame_mode
                           && (row_count == cfg.polarity_scheme_code - 3'h1);
  wire        pol_flip   = frame_mode ? frame_strobe : row_wrap;

  logic [2:0] next_row_count;

  always_comb begin
    next_row_count = row_count;
    if (frame_mode || frame_strobe || dec_inv) begin
      next_row_count = 3'h0;
    end else if (row_wrap) begin
      next_row_count = 3'h0;
    end else if (row_strobe) begin
      next_row_count = row_count + 3'h1;
    end
  end

  // Polarity register and row counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_count      <= 3'h0;
      drive_polarity <= 1'b0;
    end else begin
      row_count      <= next_row_count;
      drive_polarity <= pol_flip ? !drive_polarity : drive_polarity;
    end
  end

endmodule : ldsc_core

// ### verilog/ldsc_pkg.sv
// Package: constants, types and lookup for the LCD setup command decoder
package ldsc_pkg;

  // Command qualifier and opcode patterns
  localparam logic [1:0] RS_CTRL       = 2'h2;
  localparam logic [7:0] OP_HOME       = 8'h01;
  localparam logic [5:0] OP_ENTRY_HI   = 6'h0A;
  localparam logic [5:0] OP_FUNC_HI    = 6'h0C;
  localparam logic [4:0] OP_INV_HI     = 5'h08;
  localparam logic [2:0] OP_RATE_HI    = 3'h4;

  // Values after reset
  localparam logic       RST_STEP_DIR  = 1'h1;
  localparam logic       RST_SHIFT_EN  = 1'h0;
  localparam logic       RST_TWO_LINE  = 1'h0;
  localparam logic       RST_MUX       = 1'h0;
  localparam logic [2:0] RST_INV       = 3'h0;
  localparam logic [4:0] RST_RATE      = 5'h07;
  localparam logic [6:0] RST_DUTY      = 7'h0B;

  // Geometry
  localparam int ADDR_W   = 7;
  localparam int SHIFT_W  = 6;
  localparam int LINE_LEN = 40;

  // Memory bank of a data access
  typedef enum logic [1:0] {
    LDSC_BANK_DISPLAY = 2'b00,
    LDSC_BANK_PATTERN = 2'b01,
    LDSC_BANK_ICON    = 2'b10,
    LDSC_BANK_ROM     = 2'b11
  } ldsc_bank_t;

  // One instruction from the serial front end
  typedef struct packed {
    logic [1:0] register_select;
    logic       read_not_write;
    logic [7:0] data;
  } ldsc_cmd_t;

  // Stored configuration
  typedef struct packed {
    logic       step_dir;
    logic       shift_en;
    logic       two_line;
    logic       mux_ratio_select;
    logic [2:0] polarity_scheme_code;
    logic [4:0] refresh_rate_code;
  } ldsc_cfg_t;

  localparam ldsc_cfg_t RST_CFG = '{RST_STEP_DIR, RST_SHIFT_EN, RST_TWO_LINE,
                                    RST_MUX, RST_INV, RST_RATE};

  // On-part of the drive duty cycle in percent per refresh rate code
  function automatic logic [6:0] ldsc_duty(input logic [4:0] code);
    logic [6:0] d;
    d = 7'h32;
    case (code)
      5'h00: d = 7'h32;
      5'h01: d = 7'h2C;
      5'h02: d = 7'h26;
      5'h03: d = 7'h21;
      5'h04: d = 7'h1B;
      5'h05: d = 7'h17;
      5'h06: d = 7'h0F;
      5'h07: d = 7'h0B;
      5'h08: d = 7'h05;
      5'h09: d = 7'h32;
      5'h0A: d = 7'h2E;
      5'h0B: d = 7'h2A;
      5'h0C: d = 7'h26;
      5'h0D: d = 7'h21;
      5'h0E: d = 7'h1B;
      5'h0F: d = 7'h14;
      5'h10: d = 7'h0B;
      5'h11: d = 7'h32;
      5'h12: d = 7'h2A;
      5'h13: d = 7'h21;
      5'h14: d = 7'h14;
      default: d = 7'h32;
    endcase
    return d;
  endfunction : ldsc_duty

endpackage : ldsc_pkg
